// [hdl/flc_cfg.svh]
// constants for the fastlock/latch/init control block: bit positions, codes, timing
// assumes inclusion by bare name from package and modules
`ifndef FLC_CFG_SVH
`define FLC_CFG_SVH
`define FLC_WORD_W        24
`define FLC_SEL_REF       2'h0
`define FLC_SEL_FB        2'h1
`define FLC_SEL_FUNC      2'h2
`define FLC_SEL_INIT      2'h3
`define FLC_B_HOLD        2
`define FLC_B_PD_REQ      3
`define FLC_B_TRISTATE    8
`define FLC_B_FL_EN       9
`define FLC_B_FL_MODE     10
`define FLC_B_TO_LSB      11
`define FLC_B_TO_MSB      14
`define FLC_B_PRI_LSB     15
`define FLC_B_PRI_MSB     17
`define FLC_B_SEC_LSB     18
`define FLC_B_SEC_MSB     20
`define FLC_B_PD_SYNC     21
`define FLC_B_GAIN        21
`define FLC_CLK_NS        10
`define FLC_BIAS_NS       1000
`define FLC_BIAS_CYC      ((`FLC_BIAS_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_DIV_HALF      4
`define FLC_TO_UNIT       16'h0003
`endif

// [hdl/flc_pkg.sv]
// types shared by both ends of the fastlock/latch/init link
// assumes flc_cfg.svh for widths
`include "flc_cfg.svh"
package flc_pkg;
   typedef logic [`FLC_WORD_W-1:0] flc_word_t;
   typedef enum logic [1:0] {FLC_IDLE, FLC_SHIFT, FLC_STROBE, FLC_GAP} flc_ser_e;
endpackage

// [hdl/flc_link_if.sv]
// three-wire serial link plus chip enable between host and device
// assumes both ends on core_clk_in; link clock is a plain sampled wire
`timescale 1ns/100ps
interface flc_link_if;
   logic ser_clk;
   logic ser_data;
   logic load_strobe;
   logic chip_en;
   modport dev (input ser_clk, input ser_data, input load_strobe, input chip_en);
   modport host (output ser_clk, output ser_data, output load_strobe, output chip_en);
endinterface

// [hdl/flc_host.sv]
// host end: serialises 24-bit words msb first and drives chip enable
// assumes a register port on core_clk_in; link clock made here by a divider
`timescale 1ns/100ps
`include "flc_cfg.svh"
module flc_host
(
   // clock and reset
   input  wire logic                core_clk_in,
   input  wire logic                arst_n_in,
   // register port
   input  wire logic [1:0]          addr_in,
   input  wire logic [31:0]         wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [31:0]         rdata_out,
   // link
   flc_link_if.host                 link
);
   // 0: word to send (write starts transfer), 1: control bit0 = chip enable, 2: status bit0 busy
   localparam logic [1:0] ADDR_WORD = 2'h0;
   localparam logic [1:0] ADDR_CTRL = 2'h1;
   localparam logic [1:0] ADDR_STAT = 2'h2;

   flc_pkg::flc_word_t  shift_reg;
   flc_pkg::flc_ser_e   state_reg;
   logic [4:0]          bit_cnt_reg;
   logic [3:0]          div_reg;
   logic                sclk_reg;
   logic                ce_reg;
   logic                strobe_reg;
   logic                tick;

   ////////////////////////////////////////////////////////////////////////////
   // half-period enable for the link clock
   assign tick = (div_reg == 4'(`FLC_DIV_HALF - 1));
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         div_reg <= 4'h0;
      else if (tick)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end

   // word shifter; writes while busy are dropped, software polls busy
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_reg   <= flc_pkg::FLC_IDLE;
         shift_reg   <= '0;
         bit_cnt_reg <= 5'h00;
         sclk_reg    <= 1'b0;
         strobe_reg  <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            flc_pkg::FLC_IDLE:
               if (wr_in && addr_in == ADDR_WORD)
               begin
                  shift_reg   <= wdata_in[`FLC_WORD_W-1:0];
                  bit_cnt_reg <= 5'(`FLC_WORD_W);
                  state_reg   <= flc_pkg::FLC_SHIFT;
               end
            flc_pkg::FLC_SHIFT:
               if (tick)
               begin
                  // data stable on low phase, falling edge shifts it
                  if (sclk_reg)
                  begin
                     sclk_reg    <= 1'b0;
                     shift_reg   <= {shift_reg[`FLC_WORD_W-2:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg - 5'h01;
                     if (bit_cnt_reg == 5'h01)
                        state_reg <= flc_pkg::FLC_STROBE;
                  end
                  else
                     sclk_reg <= 1'b1;
               end
            flc_pkg::FLC_STROBE:
               if (tick)
               begin
                  strobe_reg <= ~strobe_reg; // strobe rise latches the word
                  if (strobe_reg)
                     state_reg <= flc_pkg::FLC_GAP;
               end
            flc_pkg::FLC_GAP:
               if (tick)
                  state_reg <= flc_pkg::FLC_IDLE;
         endcase
      end
   end

   // chip enable; low powers the device down while programming
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ce_reg <= 1'b0;
      else if (wr_in && addr_in == ADDR_CTRL)
         ce_reg <= wdata_in[0];
   end

   // read data one cycle after strobe
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_out <= 32'h0000_0000;
      else if (rd_in)
         unique case (addr_in)
            ADDR_CTRL: rdata_out <= {31'h0, ce_reg};
            ADDR_STAT: rdata_out <= {31'h0, state_reg != flc_pkg::FLC_IDLE};
            default:   rdata_out <= 32'h0000_0000;
         endcase
      else
         rdata_out <= 32'h0000_0000;
   end

   assign link.ser_clk     = sclk_reg;
   assign link.ser_data    = shift_reg[`FLC_WORD_W-1];
   assign link.load_strobe = strobe_reg;
   assign link.chip_en     = ce_reg;
endmodule

// [hdl/flc_dev.sv]
// device end: serial latches, fastlock control, pump select and init reset pulse
// assumes link pins asynchronous to core_clk_in; pfd_tick_in is a same-clock pulse
//
// Behaviour
// - fastlock only while enable bit set
// - mode bit picks mode one or two
// - fastlock uses second current setting
// - gain bit write enters fastlock
// - mode one exits on gain cleared
// - mode two timeout clears gain itself
// - timeout select from four bits
// - timer runs only in mode two
// - current codes from low/high fields
// - three-state bit floats pump output
// - init word loads function, pulses reset
// - init load resets counters, floats pump
// - init pulse triggers chosen sync power-down
// - reset pulse spares reference and buffer
// - first feedback load after init pulses
// - host writes init, function, ref, feedback
// - chip enable low powers down; 1 us settle
// - latches survive chip enable power-down
// - host brackets loads with counter hold
// - counter hold: load point, float, no power-down
// - 24 bits msb first, strobe latches
// - counter hold bit resets counters
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "flc_cfg.svh"
module flc_dev
#(
   parameter int BIAS_CYC = `FLC_BIAS_CYC
)
(
   // clock and reset
   input  wire logic                core_clk_in,
   input  wire logic                arst_n_in,
   // link
   flc_link_if.dev                  link,
   // phase detector event pulse from the counters
   input  wire logic                pfd_tick_in,
   // pump control
   output logic      [2:0]          pump_current_out,
   output logic                     pump_output_en_out,
   output logic                     boost_gain_flag_out,
   // counter and power control
   output logic                     counter_reset_out,
   output logic                     init_pulse_out,
   output logic                     power_down_out,
   output logic                     bias_ready_out,
   // latched words
   output logic      [`FLC_WORD_W-1:0] ref_word_out,
   output logic      [`FLC_WORD_W-1:0] fb_word_out,
   output logic      [`FLC_WORD_W-1:0] func_word_out
);
   flc_pkg::flc_word_t  shift_reg;
   flc_pkg::flc_word_t  func_reg;
   logic [2:0]          sclk_sync_reg;
   logic [1:0]          data_sync_reg;
   logic [2:0]          strobe_sync_reg;
   logic [1:0]          ce_sync_reg;
   logic                gain_reg;
   logic                arm_reg;
   logic                pulse_reg;
   logic                pd_sync_pend_reg;
   logic                pd_sync_reg;
   logic [15:0]         to_cnt_reg;
   logic [$clog2(BIAS_CYC+1)-1:0] bias_cnt_reg;
   logic                sclk_rise;
   logic                strobe_rise;
   logic [1:0]          latch_select;
   logic                fl_active;

   // timeout length per select code in pfd cycles
   function automatic logic [15:0] to_len(input logic [3:0] code);
      to_len = 16'(({12'h000, code} + 16'h0001) * `FLC_TO_UNIT);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers; third stage only for edge detection
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sclk_sync_reg <= 3'h0;
         data_sync_reg   <= 2'h0;
         strobe_sync_reg <= 3'h0;
         ce_sync_reg   <= 2'h0;
      end
      else
      begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], link.ser_clk};
         data_sync_reg   <= {data_sync_reg[0], link.ser_data};
         strobe_sync_reg <= {strobe_sync_reg[1:0], link.load_strobe};
         ce_sync_reg   <= {ce_sync_reg[0], link.chip_en};
      end
   end
   // data and clock share two stages, so the bit read lines up with the edge seen
   assign sclk_rise    = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign strobe_rise  = strobe_sync_reg[1] & ~strobe_sync_reg[2];
   assign latch_select = shift_reg[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // input shift register, msb first on link clock rise
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         shift_reg <= '0;
      else if (sclk_rise)
         shift_reg <= {shift_reg[`FLC_WORD_W-2:0], data_sync_reg[1]};
   end

   // latches; untouched by chip enable so contents survive power-down
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         func_reg     <= '0;
         ref_word_out <= '0;
         fb_word_out  <= '0;
      end
      else if (strobe_rise)
      begin
         unique case (latch_select)
            `FLC_SEL_REF:  ref_word_out <= shift_reg;
            `FLC_SEL_FB:   fb_word_out  <= shift_reg;
            `FLC_SEL_FUNC,
            `FLC_SEL_INIT: func_reg     <= shift_reg;
         endcase
      end
   end
   assign func_word_out = func_reg;

   ////////////////////////////////////////////////////////////////////////////
   // gain flag: set or cleared by feedback loads, cleared by mode-two timeout
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         gain_reg <= 1'b0;
      else if (strobe_rise && latch_select == `FLC_SEL_FB)
         gain_reg <= shift_reg[`FLC_B_GAIN];
      else if (fl_active && func_reg[`FLC_B_FL_MODE] && pfd_tick_in && to_cnt_reg == 16'h0001)
         gain_reg <= 1'b0;
   end
   assign fl_active = func_reg[`FLC_B_FL_EN] & gain_reg;

   // timer counts pfd events only in mode two; reloads on each gain write
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         to_cnt_reg <= 16'h0000;
      else if ((strobe_rise && latch_select == `FLC_SEL_FB) || pulse_reg || power_down_out)
         to_cnt_reg <= to_len(func_reg[`FLC_B_TO_MSB:`FLC_B_TO_LSB]);
      else if (fl_active && func_reg[`FLC_B_FL_MODE] && pfd_tick_in && to_cnt_reg != 16'h0000)
         to_cnt_reg <= to_cnt_reg - 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // init reset pulse: on init load, and once on next feedback load
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         arm_reg   <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else
      begin
         pulse_reg <= strobe_rise
                      && (latch_select == `FLC_SEL_INIT || (latch_select == `FLC_SEL_FB && arm_reg));
         if (strobe_rise && latch_select == `FLC_SEL_INIT)
            arm_reg <= 1'b1;
         else if (strobe_rise && latch_select == `FLC_SEL_FB)
            arm_reg <= 1'b0;
      end
   end
   // counters, pump output enable and sync power-down see the pulse; reference and buffer enables never do
   assign init_pulse_out = pulse_reg;

   // sync power-down: armed by pulse with sync select, taken on next pump event
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pd_sync_pend_reg <= 1'b0;
         pd_sync_reg      <= 1'b0;
      end
      else if (!func_reg[`FLC_B_PD_REQ] || !func_reg[`FLC_B_PD_SYNC])
      begin
         pd_sync_pend_reg <= 1'b0;
         pd_sync_reg      <= 1'b0;
      end
      else
      begin
         if (pulse_reg && ce_sync_reg[1])
            pd_sync_pend_reg <= 1'b1;
         if (pd_sync_pend_reg && pfd_tick_in)
            pd_sync_reg <= 1'b1;
      end
   end

   // counter hold never drives the power-down path
   assign power_down_out = ~ce_sync_reg[1] | pd_sync_reg
                           | (func_reg[`FLC_B_PD_REQ] & ~func_reg[`FLC_B_PD_SYNC]);

   // bias settle time after chip enable rises
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         bias_cnt_reg <= '0;
      else if (!ce_sync_reg[1])
         bias_cnt_reg <= '0;
      else if (bias_cnt_reg != ($clog2(BIAS_CYC+1))'(BIAS_CYC))
         bias_cnt_reg <= bias_cnt_reg + 1'b1;
   end
   assign bias_ready_out = (bias_cnt_reg == ($clog2(BIAS_CYC+1))'(BIAS_CYC));

   ////////////////////////////////////////////////////////////////////////////
   // pump and counter controls
   assign counter_reset_out   = func_reg[`FLC_B_HOLD] | pulse_reg | power_down_out;
   assign pump_current_out    = fl_active ? func_reg[`FLC_B_SEC_MSB:`FLC_B_SEC_LSB]
                                          : func_reg[`FLC_B_PRI_MSB:`FLC_B_PRI_LSB];
   assign pump_output_en_out  = ~func_reg[`FLC_B_TRISTATE] & ~counter_reset_out;
   assign boost_gain_flag_out = gain_reg;
endmodule

// [verification/flc_link_properties.sv]
// checks on the link wires and the device pump and power outputs
// assumes one clock domain, core_clk_in, with async active-low reset
`timescale 1ns/100ps
module flc_link_properties
(
   // clock and reset
   input wire logic        core_clk_in,
   input wire logic        arst_n_in,
   // link wires
   input wire logic        ser_clk,
   input wire logic        ser_data,
   input wire logic        load_strobe,
   input wire logic        chip_en,
   // device outputs
   input wire logic [2:0]  pump_current_out,
   input wire logic        pump_output_en_out,
   input wire logic        boost_gain_flag_out,
   input wire logic        counter_reset_out,
   input wire logic        init_pulse_out,
   input wire logic        power_down_out,
   input wire logic [23:0] func_word_out
);
   default clocking dc @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   // wire-level shapes
   sequence clk_high_run;
      ser_clk [*4] ##1 !ser_clk;
   endsequence
   sequence ce_low_run;
      !chip_en ##1 !chip_en ##1 !chip_en;
   endsequence
   chk_clk_half:
      assert property ($rose(ser_clk) |-> clk_high_run) else $error("link clock high phase wrong");
   chk_data_steady:
      assert property ($rose(ser_clk) |-> $stable(ser_data)) else $error("data moved at clock rise");
   chk_strobe_len:
      assert property ($rose(load_strobe) |-> load_strobe [*4] ##1 !load_strobe) else $error("strobe length wrong");
   ////////////////////////////////////////////////////////////////////////////////
   // pump and power outputs against latched settings
   chk_pump_select:
      assert property (pump_current_out == ((func_word_out[9] && boost_gain_flag_out) ?
         func_word_out[20:18] : func_word_out[17:15])) else $error("pump current code wrong");
   chk_tristate_float:
      assert property (func_word_out[8] |-> !pump_output_en_out) else $error("pump driven in three-state");
   chk_hold_float:
      assert property (func_word_out[2] |-> counter_reset_out && !pump_output_en_out) else $error("hold not applied");
   chk_init_pulse:
      assert property (init_pulse_out |-> !pump_output_en_out ##1 !init_pulse_out) else $error("init pulse wrong");
   chk_ce_down:
      assert property (ce_low_run |-> ##1 power_down_out) else $error("no power-down with enable low");
   // gain may only fall by itself in mode two; otherwise a load must be under way
   chk_mode_one_hold:
      assert property ($fell(boost_gain_flag_out) |-> func_word_out[10] || load_strobe || $past(load_strobe))
         else $error("gain dropped without a write");
endmodule

// [verification/testbench.sv]
// self-checking bench: host and device ends joined by the link interface
// assumes host map 0 send, 1 chip enable, 2 busy; one 100 MHz clock
`timescale 1ns/100ps
`include "flc_cfg.svh"
module testbench;
   logic        core_clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic [1:0]  addr_in = 2'h0;
   logic [31:0] wdata_in = 32'h0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        pfd_tick_in = 1'b0;
   logic [31:0] rdata_out;
   logic [2:0]  pump_current_out, s, p;
   logic        pump_output_en_out, boost_gain_flag_out, counter_reset_out;
   logic        init_pulse_out, power_down_out, bias_ready_out;
   logic [23:0] ref_word_out, fb_word_out, func_word_out, r, n, w;
   int          miscompares = 0, checked = 0, cyc = 0, pulses = 0;
   flc_link_if flc_link_if_i ();
   flc_host flc_host_i (.core_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .link(flc_link_if_i.host));
   // short bias wait keeps the run brief
   flc_dev #(.BIAS_CYC(4)) flc_dev_i (.core_clk_in, .arst_n_in, .link(flc_link_if_i.dev), .pfd_tick_in,
      .pump_current_out, .pump_output_en_out, .boost_gain_flag_out, .counter_reset_out, .init_pulse_out,
      .power_down_out, .bias_ready_out, .ref_word_out, .fb_word_out, .func_word_out);
   flc_link_properties flc_link_properties_i (.core_clk_in, .arst_n_in, .ser_clk(flc_link_if_i.ser_clk),
      .ser_data(flc_link_if_i.ser_data), .load_strobe(flc_link_if_i.load_strobe),
      .chip_en(flc_link_if_i.chip_en), .pump_current_out, .pump_output_en_out, .boost_gain_flag_out,
      .counter_reset_out, .init_pulse_out, .power_down_out, .func_word_out);
   ////////////////////////////////////////////////////////////////////////////////
   always #5 core_clk_in = ~core_clk_in;
   // count reset pulses; a hang ends as a mismatch
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (init_pulse_out === 1'b1)
         pulses++;
      if (cyc == 40000)
      begin
         miscompares++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // function word: codes s and p, timeout t, mode, enable, three-state, power-down, hold
   function automatic logic [23:0] fw(logic [3:0] t, logic m, e, ts, pd, h);
      return {2'h0, pd, s, p, t, m, e, ts, 4'h0, pd, h, 2'h2};
   endfunction
   function automatic logic [23:0] fbw(logic g);
      return {2'h0, g, 13'($urandom), 8'h01};
   endfunction
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic bus(logic [1:0] a, logic [31:0] d, logic wr);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= wr;
      rd_in <= !wr;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      #1;
   endtask
   // send one word, then poll busy under a bound
   task automatic send(logic [23:0] d);
      bus(2'h0, {8'h00, d}, 1'b1);
      for (int i = 0; i < 400; i++)
      begin
         bus(2'h2, 32'h0, 1'b0);
         if (rdata_out[0] === 1'b0)
            break;
      end
      repeat (4) @(posedge core_clk_in);
      #1;
   endtask
   task automatic tick(int k);
      repeat (k)
      begin
         @(posedge core_clk_in);
         pfd_tick_in <= 1'b1;
         @(posedge core_clk_in);
         pfd_tick_in <= 1'b0;
      end
      #1;
   endtask
   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h1561));
      s = 3'($urandom);
      p = 3'($urandom);
      r = {22'($urandom), 2'h0};
      repeat (3) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      // init, function, reference, feedback, feedback
      bus(2'h1, 32'h1, 1'b1);
      bus(2'h1, 32'h0, 1'b0);
      cmp("ce readback", 1, rdata_out);
      w = fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      send(w | 24'h1);
      cmp("init pulses", 1, pulses);
      cmp("func fields", w[23:2], func_word_out[23:2]);
      send(w);
      send(r);
      send(fbw(1'b0));
      cmp("first fb pulse", 2, pulses);
      n = fbw(1'b0);
      send(n);
      cmp("later fb pulse", 2, pulses);
      cmp("ref latch", r, ref_word_out);
      cmp("fb latch", n, fb_word_out);
      $display("init test done");
      // mode one holds until written back; disabled keeps primary and no timer
      send(fw(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      send(fbw(1'b1));
      tick(20);
      cmp("gain held", 1, boost_gain_flag_out);
      cmp("boost current", s, pump_current_out);
      send(fbw(1'b0));
      cmp("gain cleared", 0, boost_gain_flag_out);
      cmp("primary", p, pump_current_out);
      send(fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      send(fbw(1'b1));
      tick(60);
      cmp("no timer", 1, boost_gain_flag_out);
      cmp("disabled", p, pump_current_out);
      $display("mode one test done");
      // mode two over every timeout code
      for (int t = 0; t < 16; t++)
      begin
         send(fw(4'(t), 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
         send(fbw(1'b1));
         tick((t + 1) * `FLC_TO_UNIT - 1);
         cmp("before timeout", 1, boost_gain_flag_out);
         tick(1);
         cmp("after timeout", 0, boost_gain_flag_out);
         cmp("reverted", p, pump_current_out);
      end
      $display("mode two test done");
      // three-state, then hold bracket with power-down bits set
      send(fw(4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
      cmp("three-state", 0, pump_output_en_out);
      send(fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
      tick(2);
      cmp("hold on", 1, counter_reset_out);
      cmp("hold no pd", 0, power_down_out);
      send(r);
      n = fbw(1'b0);
      send(n);
      send(fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      cmp("hold off", 0, counter_reset_out);
      cmp("pump back", 1, pump_output_en_out);
      $display("hold test done");
      // chip enable cycle keeps latches
      bus(2'h1, 32'h0, 1'b1);
      tick(3);
      cmp("ce down", 1, power_down_out);
      bus(2'h1, 32'h1, 1'b1);
      cmp("bias early", 0, bias_ready_out);
      tick(6);
      cmp("bias ready", 1, bias_ready_out);
      cmp("ref kept", r, ref_word_out);
      cmp("fb kept", n, fb_word_out);
      // init word choosing sync power-down waits for a pump event
      send(fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0) | 24'h1);
      cmp("sync pd waits", 0, power_down_out);
      tick(1);
      cmp("sync pd taken", 1, power_down_out);
      // power-down request without sync select acts at once
      send(fw(4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0) & 24'hDFFFFF);
      cmp("async pd", 1, power_down_out);
      $display("power test done");
      end_sim();
   end
endmodule
